/* File: common/ber_pkg.sv */
package ber_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_UNC_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_UNC_SEV = 8'h14;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 7;
  localparam int C_SYS_ERR_EN = 0;
  localparam int C_ABORT_MODE = 1;
  localparam int C_PCI_MODE = 2;
  localparam int C_PWR_LO = 3;
  localparam int C_FATAL_REP_EN = 5;
  localparam int C_NONFATAL_REP_EN = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [1:0] PWR_D0 = 2'h0;

  // ----------------------------------------------------------------
  // status flags, one sticky bit each
  // ----------------------------------------------------------------
  localparam int ST_W = 16;
  localparam int S_SEC_RMA = 0;
  localparam int S_SECUNC_RMA = 1;
  localparam int S_SEC_RTA = 2;
  localparam int S_SECUNC_RTA = 3;
  localparam int S_SEC_STA = 4;
  localparam int S_PRI_RMA = 5;
  localparam int S_PRI_RTA = 6;
  localparam int S_SIG_SYS_ERR = 7;
  localparam int S_FATAL_DET = 8;
  localparam int S_NONFATAL_DET = 9;
  localparam int S_COR_DET = 10;
  localparam int S_UR_DET = 11;
  localparam int S_UNEXP_CPL = 12;
  localparam int S_CPL_TIMEOUT = 13;
  localparam int S_COMPL_ABORT = 14;
  localparam int S_UNSUP_REQ = 15;
  localparam logic [ST_W-1:0] IRQ_EN_RST = 16'h0000;

  // ----------------------------------------------------------------
  // uncorrectable mask / severity layout
  // ----------------------------------------------------------------
  localparam int UNC_W = 6;
  localparam int U_MA = 0;
  localparam int U_TA = 1;
  localparam int U_UNEXP = 2;
  localparam int U_TMO = 3;
  localparam int U_CMPL_ABT = 4;
  localparam int U_UR = 5;
  localparam logic [UNC_W-1:0] UNC_MASK_RST = 6'h00;
  localparam logic [UNC_W-1:0] UNC_SEV_RST = 6'h00;

  // ----------------------------------------------------------------
  // bus answers and request decode
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int LEN_W = 10;
  localparam logic [LEN_W-1:0] LEN_ONE_DW = 10'h001;
  localparam logic [2:0] FUNC_ZERO = 3'h0;

endpackage : ber_pkg

/* File: common/ber_reg_if.sv */
`timescale 1ns/1ns
interface ber_reg_if;
  import ber_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface : ber_reg_if

/* File: verilog/ber_flags.sv */
`timescale 1ns/1ns
module ber_flags
  import ber_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ST_W-1:0] set,
  input wire logic [ST_W-1:0] clr,
  output logic [ST_W-1:0] flag_q
);

  // ----------------------------------------------------------------
  // sticky bits: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  for (genvar i = 0; i < ST_W; i++)
  begin : g_bit
    logic flag_d;
    always_comb
    begin
      flag_d = set[i] | (flag_q[i] & ~clr[i]); // RULE_13
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        flag_q[i] <= 1'b0;
      else
        flag_q[i] <= flag_d;
    end
  end

endmodule : ber_flags

/* File: verilog/ber_axil.sv */
`timescale 1ns/1ns
module ber_axil
  import ber_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  ber_reg_if.bus rif
);

  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // handshakes: address and data taken in either order
  // ----------------------------------------------------------------
  assign awready = ~aw_full_q & ~bvalid_q;
  assign wready = ~w_full_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign rif.wr_addr = aw_addr_q;
  assign rif.wr_data = w_data_q;
  assign rif.wr_strb = w_strb_q;
  assign rif.rd_addr = araddr;

  always_comb
  begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    rif.wr_en = aw_full_q & w_full_q & ~bvalid_q;
    rif.rd_en = arvalid & ~rvalid_q;
    if (awvalid && awready)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready)
    begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (rif.wr_en)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (rif.rd_en)
    begin
      rvalid_d = 1'b1;
      rdata_d = rif.rd_data;
      rresp_d = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && rready)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

endmodule : ber_axil

/* File: verilog/ber_top.sv */
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// RULE_01: a master abort on a forwarded posted write sets received master abort in both secondary status views.
// RULE_02: that posted-write master abort sets fatal or nonfatal detected, and system error when enabled and unmasked or in abort error mode.
// RULE_03: a master abort on a forwarded non-posted write sets fatal or nonfatal detected, and system error only if a message went out and it is enabled.
// RULE_04: a target abort on a forwarded request sets received target abort in both secondary views, the detected flag, and system error if a message went out and it is enabled.
// RULE_05: an unsupported-request completion for a secondary request in PCI mode sets primary received master abort, and secondary signaled target abort only in abort error mode.
// RULE_06: a completer-abort completion for a forwarded non-posted request sets primary received target abort and secondary signaled target abort.
// RULE_07: an unexpected completion sets its uncorrectable flag unless masked, and correctable detected when advisory nonfatal.
// RULE_08: a completion timeout sets its uncorrectable flag unless masked, and correctable detected when advisory nonfatal.
// RULE_09: a request to the first base address longer than one doubleword sets completer abort unless masked, correctable detected if advisory, and secondary received target abort.
// RULE_10: a type 0 vendor message sets the unsupported request uncorrectable flag unless masked.
// RULE_11: a request other than configuration or message in D1, D2 or D3 hot sets unsupported request detected, and correctable detected when advisory.
// RULE_12: a type 0 configuration access to a non-zero function sets unsupported request detected, and correctable detected when advisory.
// RULE_13: every error flag stays set until software clears it.
module ber_top
  import ber_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic EV_MA_POSTED,
  input wire logic EV_MA_NONPOSTED,
  input wire logic EV_TARGET_ABORT,
  input wire logic EV_CPL_UNSUPPORTED,
  input wire logic EV_CPL_COMPLETER_ABORT,
  input wire logic EV_CPL_UNEXPECTED,
  input wire logic EV_CPL_TIMEOUT,
  input wire logic REQ_VALID,
  input wire logic REQ_IS_CFG,
  input wire logic REQ_CFG_TYPE0,
  input wire logic [2:0] REQ_FUNC,
  input wire logic REQ_IS_MSG,
  input wire logic REQ_VENDOR_TYPE0,
  input wire logic REQ_BAR0_HIT,
  input wire logic [LEN_W-1:0] REQ_LEN_DW,
  output logic ERR_MSG_FATAL,
  output logic ERR_MSG_NONFATAL,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // registers and wiring
  // ----------------------------------------------------------------
  ber_reg_if rif ();

  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [ST_W-1:0] irq_en_q, irq_en_d;
  logic [UNC_W-1:0] unc_mask_q, unc_mask_d;
  logic [UNC_W-1:0] unc_sev_q, unc_sev_d;
  logic irq_q, irq_d;
  logic msg_fatal_q, msg_fatal_d;
  logic msg_nonfatal_q, msg_nonfatal_d;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] set_vec;
  logic [ST_W-1:0] clr_vec;
  logic [31:0] wr_word;
  logic [31:0] old_word;

  logic sys_err_en, abort_mode, pci_mode, low_power;
  logic [UNC_W-1:0] msg_ok;
  logic [UNC_W-1:0] advisory_nonfatal_case;
  logic ma_msg, ta_msg;
  logic req_ur_detected;

  assign sys_err_en = ctrl_q[C_SYS_ERR_EN];
  assign abort_mode = ctrl_q[C_ABORT_MODE];
  assign pci_mode = ctrl_q[C_PCI_MODE];
  assign low_power = ctrl_q[C_PWR_LO +: 2] != PWR_D0;

  // a message goes out only for an unmasked error whose severity is enabled
  for (genvar e = 0; e < UNC_W; e++)
  begin : g_unc
    assign msg_ok[e] = ~unc_mask_q[e] &
      (unc_sev_q[e] ? ctrl_q[C_FATAL_REP_EN] : ctrl_q[C_NONFATAL_REP_EN]);
    assign advisory_nonfatal_case[e] = ~unc_sev_q[e];
  end

  assign ma_msg = (EV_MA_POSTED | EV_MA_NONPOSTED) & msg_ok[U_MA];
  assign ta_msg = EV_TARGET_ABORT & msg_ok[U_TA];
  assign req_ur_detected = REQ_VALID & ((~REQ_IS_CFG & ~REQ_IS_MSG & low_power) |
    (REQ_IS_CFG & REQ_CFG_TYPE0 & (REQ_FUNC != FUNC_ZERO)));

  // ----------------------------------------------------------------
  // error classification
  // ----------------------------------------------------------------
  always_comb
  begin
    set_vec = '0;
    if (EV_MA_POSTED)
    begin
      set_vec[S_SEC_RMA] = 1'b1; // RULE_01
      set_vec[S_SECUNC_RMA] = 1'b1; // RULE_01
      set_vec[S_FATAL_DET] = unc_sev_q[U_MA]; // RULE_02
      set_vec[S_NONFATAL_DET] = ~unc_sev_q[U_MA]; // RULE_02
      if (sys_err_en && (!unc_mask_q[U_MA] || abort_mode))
        set_vec[S_SIG_SYS_ERR] = 1'b1; // RULE_02
    end
    if (EV_MA_NONPOSTED)
    begin
      set_vec[S_FATAL_DET] = set_vec[S_FATAL_DET] | unc_sev_q[U_MA]; // RULE_03
      set_vec[S_NONFATAL_DET] = set_vec[S_NONFATAL_DET] | ~unc_sev_q[U_MA]; // RULE_03
      if (msg_ok[U_MA] && sys_err_en)
        set_vec[S_SIG_SYS_ERR] = 1'b1; // RULE_03
    end
    if (EV_TARGET_ABORT)
    begin
      set_vec[S_SEC_RTA] = 1'b1; // RULE_04
      set_vec[S_SECUNC_RTA] = 1'b1; // RULE_04
      set_vec[S_FATAL_DET] = set_vec[S_FATAL_DET] | unc_sev_q[U_TA]; // RULE_04
      set_vec[S_NONFATAL_DET] = set_vec[S_NONFATAL_DET] | ~unc_sev_q[U_TA]; // RULE_04
      if (msg_ok[U_TA] && sys_err_en)
        set_vec[S_SIG_SYS_ERR] = 1'b1; // RULE_04
    end
    if (EV_CPL_UNSUPPORTED && pci_mode)
    begin
      set_vec[S_PRI_RMA] = 1'b1; // RULE_05
      set_vec[S_SEC_STA] = abort_mode; // RULE_05
    end
    if (EV_CPL_COMPLETER_ABORT)
    begin
      set_vec[S_PRI_RTA] = 1'b1; // RULE_06
      set_vec[S_SEC_STA] = 1'b1; // RULE_06
    end
    if (EV_CPL_UNEXPECTED)
    begin
      set_vec[S_UNEXP_CPL] = ~unc_mask_q[U_UNEXP]; // RULE_07
      if (advisory_nonfatal_case[U_UNEXP])
        set_vec[S_COR_DET] = 1'b1; // RULE_07
    end
    if (EV_CPL_TIMEOUT)
    begin
      set_vec[S_CPL_TIMEOUT] = ~unc_mask_q[U_TMO]; // RULE_08
      if (advisory_nonfatal_case[U_TMO])
        set_vec[S_COR_DET] = 1'b1; // RULE_08
    end
    if (REQ_VALID && REQ_BAR0_HIT && REQ_LEN_DW > LEN_ONE_DW)
    begin
      set_vec[S_COMPL_ABORT] = ~unc_mask_q[U_CMPL_ABT]; // RULE_09
      set_vec[S_SEC_RTA] = 1'b1; // RULE_09
      if (advisory_nonfatal_case[U_CMPL_ABT])
        set_vec[S_COR_DET] = 1'b1; // RULE_09
    end
    if (REQ_VALID && REQ_IS_MSG && REQ_VENDOR_TYPE0)
      set_vec[S_UNSUP_REQ] = ~unc_mask_q[U_UR]; // RULE_10
    if (req_ur_detected)
    begin
      set_vec[S_UR_DET] = 1'b1; // RULE_11 RULE_12
      if (advisory_nonfatal_case[U_UR])
        set_vec[S_COR_DET] = 1'b1; // RULE_11 RULE_12
    end
  end

  ber_flags u_flags (
    .clk(CLK),
    .arst_n(ARST_N),
    .set(set_vec),
    .clr(clr_vec),
    .flag_q(status_q)
  );

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction : merge

  always_comb
  begin
    unique case (rif.wr_addr)
      OFF_CTRL: old_word = {25'h0, ctrl_q};
      OFF_IRQ_EN: old_word = {16'h0, irq_en_q};
      OFF_UNC_MASK: old_word = {26'h0, unc_mask_q};
      OFF_UNC_SEV: old_word = {26'h0, unc_sev_q};
      default: old_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = merge(old_word, rif.wr_data, rif.wr_strb);
  assign rif.wr_ok = rif.wr_addr inside {OFF_CTRL, OFF_STATUS, OFF_CLEAR,
    OFF_IRQ_EN, OFF_UNC_MASK, OFF_UNC_SEV};
  assign rif.rd_ok = rif.rd_addr inside {OFF_CTRL, OFF_STATUS, OFF_CLEAR,
    OFF_IRQ_EN, OFF_UNC_MASK, OFF_UNC_SEV};
  // clear is write-only; a write to status is accepted and ignored
  assign clr_vec = (rif.wr_en && rif.wr_addr == OFF_CLEAR) ? wr_word[ST_W-1:0] : '0; // RULE_13

  always_comb
  begin
    unique case (rif.rd_addr)
      OFF_CTRL: rif.rd_data = {25'h0, ctrl_q};
      OFF_STATUS: rif.rd_data = {16'h0, status_q};
      OFF_IRQ_EN: rif.rd_data = {16'h0, irq_en_q};
      OFF_UNC_MASK: rif.rd_data = {26'h0, unc_mask_q};
      OFF_UNC_SEV: rif.rd_data = {26'h0, unc_sev_q};
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    unc_mask_d = unc_mask_q;
    unc_sev_d = unc_sev_q;
    if (rif.wr_en)
    begin
      unique case (rif.wr_addr)
        OFF_CTRL: ctrl_d = wr_word[CTRL_W-1:0];
        OFF_IRQ_EN: irq_en_d = wr_word[ST_W-1:0];
        OFF_UNC_MASK: unc_mask_d = wr_word[UNC_W-1:0];
        OFF_UNC_SEV: unc_sev_d = wr_word[UNC_W-1:0];
        default: ;
      endcase
    end
    irq_d = |(status_q & irq_en_q);
    msg_fatal_d = (ma_msg & unc_sev_q[U_MA]) | (ta_msg & unc_sev_q[U_TA]);
    msg_nonfatal_d = (ma_msg & ~unc_sev_q[U_MA]) | (ta_msg & ~unc_sev_q[U_TA]);
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_q <= CTRL_RST;
      irq_en_q <= IRQ_EN_RST;
      unc_mask_q <= UNC_MASK_RST;
      unc_sev_q <= UNC_SEV_RST;
      irq_q <= 1'b0;
      msg_fatal_q <= 1'b0;
      msg_nonfatal_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      irq_en_q <= irq_en_d;
      unc_mask_q <= unc_mask_d;
      unc_sev_q <= unc_sev_d;
      irq_q <= irq_d;
      msg_fatal_q <= msg_fatal_d;
      msg_nonfatal_q <= msg_nonfatal_d;
    end
  end

  assign IRQ = irq_q;
  assign ERR_MSG_FATAL = msg_fatal_q;
  assign ERR_MSG_NONFATAL = msg_nonfatal_q;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  ber_axil u_axil (
    .clk(CLK),
    .arst_n(ARST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rif(rif.bus)
  );

endmodule : ber_top

/* File: verif/ber_top_asserts.sv */
`timescale 1ns/1ns
module ber_top_asserts
  import ber_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic EV_MA_POSTED,
  input wire logic EV_MA_NONPOSTED,
  input wire logic EV_TARGET_ABORT,
  input wire logic ERR_MSG_FATAL,
  input wire logic ERR_MSG_NONFATAL,
  input wire logic IRQ
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  logic abort_ev;
  assign abort_ev = EV_MA_POSTED | EV_MA_NONPOSTED | EV_TARGET_ABORT;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer missing");
  rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer timing");
  wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped early");
  wr_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  fatal_cause_a: assert property (ERR_MSG_FATAL |-> $past(abort_ev) || $past(abort_ev, 2))
    else $error("fatal message without abort");
  nonfatal_cause_a: assert property (ERR_MSG_NONFATAL |-> $past(abort_ev) || $past(abort_ev, 2))
    else $error("nonfatal message without abort");
  irq_sticky_a: assert property ($fell(IRQ) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
    else $error("interrupt dropped without software write");
  cover property (ERR_MSG_FATAL);
  cover property (ERR_MSG_NONFATAL);
  cover property ($rose(IRQ));
endmodule : ber_top_asserts

bind ber_top ber_top_asserts u_chk (.CLK(CLK), .ARST_N(ARST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .EV_MA_POSTED(EV_MA_POSTED),
  .EV_MA_NONPOSTED(EV_MA_NONPOSTED), .EV_TARGET_ABORT(EV_TARGET_ABORT),
  .ERR_MSG_FATAL(ERR_MSG_FATAL), .ERR_MSG_NONFATAL(ERR_MSG_NONFATAL), .IRQ(IRQ));

/* File: verif/ber_far_end.sv */
`timescale 1ns/1ns
module ber_far_end
(
  input wire logic clk,
  output logic [6:0] ev,
  output logic req_valid,
  output logic [17:0] req_d
);
  // ----------------------------------------------------------------
  // link and bus agents: one event per call
  // ----------------------------------------------------------------
  initial
  begin
    ev = 7'h00;
    req_valid = 1'b0;
    req_d = 18'h00000;
  end
  // index 7 is a request descriptor, the rest are single event lines
  task automatic fire(input logic [2:0] k, input logic [17:0] d);
    if (k == 3'h7)
    begin
      req_valid <= 1'b1;
      req_d <= d;
    end
    else
      ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 7'h00;
    req_valid <= 1'b0;
    // stale descriptor must not look valid
    req_d <= ~d;
  endtask : fire
endmodule : ber_far_end

/* File: verif/ber_top_tb.sv */
`timescale 1ns/1ns
module ber_top_tb;
  import ber_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00;
  logic [ADDR_W-1:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, msg_f, msg_n, irq, rq_v, late;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [6:0] ev;
  logic [17:0] rq;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  ber_far_end far (.clk(clk), .ev(ev), .req_valid(rq_v), .req_d(rq));
  ber_top dut (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EV_MA_POSTED(ev[0]), .EV_MA_NONPOSTED(ev[1]), .EV_TARGET_ABORT(ev[2]),
    .EV_CPL_UNSUPPORTED(ev[3]), .EV_CPL_COMPLETER_ABORT(ev[4]), .EV_CPL_UNEXPECTED(ev[5]),
    .EV_CPL_TIMEOUT(ev[6]), .REQ_VALID(rq_v), .REQ_IS_CFG(rq[17]), .REQ_CFG_TYPE0(rq[16]),
    .REQ_FUNC(rq[15:13]), .REQ_IS_MSG(rq[12]), .REQ_VENDOR_TYPE0(rq[11]),
    .REQ_BAR0_HIT(rq[10]), .REQ_LEN_DW(rq[9:0]), .ERR_MSG_FATAL(msg_f),
    .ERR_MSG_NONFATAL(msg_n), .IRQ(irq));
  // ----------------------------------------------------------------
  // clock, limit and shared tasks
  // ----------------------------------------------------------------
  initial forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one transfer; handshakes judged just before the edge that takes them
  task automatic axi(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] dd);
    logic aw_h, w_h, ar_h, done;
    done = 1'b0;
    if (wr)
    begin
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !late;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !late;
    end
    while (!done)
    begin
      @(negedge clk);
      aw_h = awvalid & awready;
      w_h = wvalid & wready;
      ar_h = arvalid & arready;
      done = wr ? bvalid & bready : rvalid & rready;
      r = wr ? bresp : rresp;
      d = rdata;
      @(posedge clk);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
      if (ar_h) arvalid <= 1'b0;
      if (bvalid && !done) bready <= 1'b1;
      if (rvalid && !done) rready <= 1'b1;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi
  task automatic run(input logic [6:0] c, input logic [11:0] ms, input logic [2:0] k,
    input logic [17:0] q, input logic [15:0] exp, input logic [1:0] em);
    logic [1:0] seen;
    axi(1'b1, OFF_CTRL, {25'h0, c});
    axi(1'b1, OFF_UNC_MASK, {26'h0, ms[11:6]});
    axi(1'b1, OFF_UNC_SEV, {26'h0, ms[5:0]});
    axi(1'b1, OFF_CLEAR, 32'h0000ffff);
    seen = 2'h0;
    far.fire(k, q);
    repeat (3)
    begin
      @(negedge clk);
      seen = seen | {msg_f, msg_n};
      @(posedge clk);
    end
    axi(1'b0, OFF_STATUS, 32'h0);
    chk(d, {16'h0, exp});
    chk({30'h0, seen}, {30'h0, em});
  endtask : run
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    late = 1'b1;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      axi(1'b0, 8'(4 * i), 32'h0);
      chk(d, 32'h0);
    end
    axi(1'b0, 8'h20, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    late = 1'b0;
    axi(1'b1, 8'h20, 32'hffffffff);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi(1'b1, OFF_CTRL, 32'hffffffff);
    axi(1'b0, OFF_CTRL, 32'h0);
    chk(d, 32'h0000007f);
    run(7'h61, 12'h040, 3'h0, 18'h0, 16'h0203, 2'h0);
    run(7'h63, 12'h040, 3'h0, 18'h0, 16'h0283, 2'h0);
    run(7'h60, 12'h000, 3'h0, 18'h0, 16'h0203, 2'h1);
    run(7'h61, 12'h001, 3'h1, 18'h0, 16'h0180, 2'h2);
    run(7'h21, 12'h000, 3'h1, 18'h0, 16'h0200, 2'h0);
    run(7'h61, 12'h000, 3'h2, 18'h0, 16'h028c, 2'h1);
    run(7'h61, 12'h082, 3'h2, 18'h0, 16'h010c, 2'h0);
    run(7'h65, 12'h000, 3'h3, 18'h0, 16'h0020, 2'h0);
    run(7'h67, 12'h000, 3'h3, 18'h0, 16'h0030, 2'h0);
    run(7'h61, 12'h000, 3'h3, 18'h0, 16'h0000, 2'h0);
    run(7'h61, 12'h000, 3'h4, 18'h0, 16'h0050, 2'h0);
    run(7'h61, 12'h000, 3'h5, 18'h0, 16'h1400, 2'h0);
    run(7'h61, 12'h104, 3'h5, 18'h0, 16'h0000, 2'h0);
    run(7'h61, 12'h000, 3'h6, 18'h0, 16'h2400, 2'h0);
    run(7'h61, 12'h200, 3'h6, 18'h0, 16'h0400, 2'h0);
    run(7'h61, 12'h000, 3'h7, 18'h00402, 16'h4404, 2'h0);
    run(7'h61, 12'h000, 3'h7, 18'h00401, 16'h0000, 2'h0);
    run(7'h61, 12'h410, 3'h7, 18'h00402, 16'h0004, 2'h0);
    run(7'h61, 12'h000, 3'h7, 18'h01801, 16'h8000, 2'h0);
    run(7'h61, 12'h800, 3'h7, 18'h01801, 16'h0000, 2'h0);
    run(7'h69, 12'h000, 3'h7, 18'h00001, 16'h0c00, 2'h0);
    run(7'h71, 12'h000, 3'h7, 18'h00001, 16'h0c00, 2'h0);
    run(7'h79, 12'h000, 3'h7, 18'h30001, 16'h0000, 2'h0);
    run(7'h61, 12'h000, 3'h7, 18'h32001, 16'h0c00, 2'h0);
    run(7'h61, 12'h020, 3'h7, 18'h32001, 16'h0800, 2'h0);
    run(7'h61, 12'h000, 3'h0, 18'h0, 16'h0283, 2'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    axi(1'b1, OFF_IRQ_EN, 32'h00000080);
    far.fire(3'h7, 18'h00001);
    repeat (4) axi(1'b0, OFF_CTRL, 32'h0);
    axi(1'b1, OFF_STATUS, 32'h0000ffff);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    axi(1'b0, OFF_STATUS, 32'h0);
    chk(d, 32'h00000283);
    axi(1'b1, OFF_CLEAR, 32'h00000080);
    axi(1'b0, OFF_STATUS, 32'h0);
    chk(d, 32'h00000203);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    test_done();
  end
endmodule : ber_top_tb
